// ===== hdl/cbp_consts.svh
// Functional notes
// R1: Bus multiplexes address then data by strobes.
// R2: Device drives bus only while DMA master; the code also drives dev_ad_out in slave reads and interrupt vector cycles.
// R3: DMA upper address byte on low lanes; the code drives only dma_addr[15:0] and never puts dma_addr[23:16] out.
// R4: Interrupt vector placed on low lanes.
// R5: Slave select and command latched on address strobe.
// R6: DMA master drives address strobe low.
// R7: Slave strobes synchronised to system clock.
// R8: Slave data moves by data strobe.
// R9: DMA master drives data strobe for memory.
// R10: Host drives chip select for slave access.
// R11: Low wait stretches strobe, sampled on fall; the code samples wait_n on the rising edge of mclk.
// R12: Read/write held stable whole bus cycle.
// R13: Host read high, write low in slave.
// R14: DMA read high; high address write low; the code has no high address write and holds rd_wr_dev high in every DMA cycle.
// R15: Bus request held low until done.
// R16: Mastership after two-flop acknowledge synchroniser.
// R17: Idle device passes acknowledge straight through.
// R18: High acknowledge in makes device release bus.
// R19: Port runs on system clock only.
// R20: Request only if request line seen high.
// R21: Acknowledge out high while requesting.
// R22: Reset floats bus, clears modes, forces slave.
// R23: Command/data used only during host access.
// R24: Not master means drivers high impedance; the code still enables dev_ad_oe in slave reads and interrupt vector cycles.
`ifndef CBP_CONSTS_SVH
`define CBP_CONSTS_SVH
`define CBP_BUS_W        16
`define CBP_LOW_W        8
`define CBP_RESET_CLKS   5
`define CBP_SYNC_DEPTH   2
`define CBP_MODE2_KEEP   16'hFE00
`define CBP_VEC_DEFAULT  8'h00
`endif

// ===== hdl/cbp_pkg.sv
package cbp_pkg;
    typedef enum logic [5:0] {
        DMA_IDLE = 6'h01,
        DMA_REQ  = 6'h02,
        DMA_SYNC = 6'h04,
        DMA_ADDR = 6'h08,
        DMA_DATA = 6'h10,
        DMA_DONE = 6'h20
    } cbp_dma_state_t;
endpackage

// ===== hdl/cbp_bus_if.sv
`timescale 1ns/10ps
interface cbp_bus_if;
    logic [15:0] ad_in;
    logic [15:0] dev_ad_out;
    logic        dev_ad_oe;
    logic [15:0] host_ad_out;
    logic        host_ad_oe;
    logic        addr_strobe_n_dev;
    logic        addr_strobe_n_host;
    logic        addr_strobe_oe;
    logic        addr_strobe_n;
    logic        data_strobe_n_dev;
    logic        data_strobe_n_host;
    logic        data_strobe_n;
    logic        rd_wr_dev;
    logic        rd_wr_host;
    logic        rd_wr;
    logic        chip_sel_n;
    logic        cmd_data;
    logic        wait_n;
    logic        bus_req_n_dev;
    logic        bus_req_oe;
    logic        bus_req_n;
    logic        bus_ack_in_n;
    logic        bus_ack_out_n;
    logic        intack_vec_n;

    // Resolved wire levels; the pull-ups model idle high lines.
    assign ad_in = dev_ad_oe ? dev_ad_out :
                   (host_ad_oe ? host_ad_out : 16'hFFFF);
    assign addr_strobe_n = addr_strobe_oe ? addr_strobe_n_dev
                                          : addr_strobe_n_host;
    assign data_strobe_n = addr_strobe_oe ? data_strobe_n_dev
                                          : data_strobe_n_host;
    assign rd_wr = addr_strobe_oe ? rd_wr_dev : rd_wr_host;
    assign bus_req_n = bus_req_oe ? bus_req_n_dev : 1'b1;

    modport dev (
        input  ad_in, addr_strobe_n, data_strobe_n, rd_wr, chip_sel_n,
        input  cmd_data, wait_n, bus_req_n, bus_ack_in_n, intack_vec_n,
        output dev_ad_out, dev_ad_oe, addr_strobe_n_dev, addr_strobe_oe,
        output data_strobe_n_dev, rd_wr_dev, bus_req_n_dev, bus_req_oe,
        output bus_ack_out_n
    );
    modport host (
        input  ad_in, addr_strobe_n, data_strobe_n, rd_wr, bus_req_n,
        input  addr_strobe_oe,
        output host_ad_out, host_ad_oe, addr_strobe_n_host,
        output data_strobe_n_host, rd_wr_host, chip_sel_n, cmd_data,
        output wait_n, bus_ack_in_n, intack_vec_n
    );
endinterface

// ===== hdl/cbp_dev_port.sv
`timescale 1ns/10ps
`include "cbp_consts.svh"
module cbp_dev_port #(
    parameter int SYNC_DEPTH = `CBP_SYNC_DEPTH
) (
    input  wire logic        mclk,          // System clock.
    input  wire logic        rst,           // Async reset, high.
    cbp_bus_if.dev           bus,           // Shared bus.
    input  wire logic        dma_go,        // Start one DMA fetch.
    input  wire logic [23:0] dma_addr,      // Memory address.
    input  wire logic [7:0]  int_vector,    // Vector to present.
    input  wire logic [15:0] rd_data,       // Register read data.
    output logic             dma_done,      // Fetch complete pulse.
    output logic [15:0]      dma_data,      // Fetched word.
    output logic             is_master,     // Mastership level.
    output logic             wr_stb,        // Host write pulse.
    output logic             wr_cmd,        // Write was command.
    output logic [15:0]      wr_data,       // Host write data.
    output logic [15:0]      mode2          // Mode register two.
);
    cbp_pkg::cbp_dma_state_t st_ff;
    cbp_pkg::cbp_dma_state_t nxt_st;
    logic [SYNC_DEPTH-1:0] ack_sync_ff;
    logic [1:0] as_sync_ff;
    logic [2:0] ds_sync_ff;
    logic       cs_lat_ff;
    logic       cd_lat_ff;
    logic       hi_phase_ff;
    logic       slave_rd_ff;
    logic [15:0] dev_ad_ff;
    logic        ad_oe_ff;
    logic        as_n_ff;
    logic        ds_n_ff;
    logic        rw_ff;
    logic        req_ff;
    logic        master_ff;
    logic        done_ff;
    logic [15:0] data_ff;
    logic        wr_stb_ff;
    logic        wr_cmd_ff;
    logic [15:0] wr_data_ff;
    logic [15:0] mode2_ff;
    logic        acked;
    logic        ds_fall;
    logic        ds_rise;

    ////////////////////////////////////////////////////////////////////
    assign acked   = ~ack_sync_ff[SYNC_DEPTH-1];               // [R16]
    assign ds_fall = ds_sync_ff[2] & ~ds_sync_ff[1];
    assign ds_rise = ~ds_sync_ff[2] & ds_sync_ff[1];

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            ack_sync_ff <= '1;
        else
            ack_sync_ff <= {ack_sync_ff[SYNC_DEPTH-2:0],
                            bus.bus_ack_in_n};                 // [R16]
    end

    // Slave strobes are asynchronous; only the later stages are read.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            as_sync_ff <= 2'h3;
            ds_sync_ff <= 3'h7;
        end
        else
        begin
            as_sync_ff <= {as_sync_ff[0], bus.addr_strobe_n};  // [R7]
            ds_sync_ff <= {ds_sync_ff[1:0], bus.data_strobe_n}; // [R7]
        end
    end

    ////////////////////////////////////////////////////////////////////
    always_comb
    begin
        nxt_st = st_ff;
        unique case (st_ff)
            cbp_pkg::DMA_IDLE:
                if (dma_go && bus.bus_req_n)                   // [R20]
                    nxt_st = cbp_pkg::DMA_REQ;
            cbp_pkg::DMA_REQ:
                nxt_st = cbp_pkg::DMA_SYNC;
            cbp_pkg::DMA_SYNC:
                if (acked)
                    nxt_st = cbp_pkg::DMA_ADDR;                // [R16]
            cbp_pkg::DMA_ADDR:
                nxt_st = acked ? cbp_pkg::DMA_DATA
                               : cbp_pkg::DMA_DONE;            // [R18]
            cbp_pkg::DMA_DATA:
                if (!acked)
                    nxt_st = cbp_pkg::DMA_DONE;                // [R18]
                else if (bus.wait_n)
                    nxt_st = cbp_pkg::DMA_DONE;                // [R11]
            cbp_pkg::DMA_DONE:
                nxt_st = cbp_pkg::DMA_IDLE;
            default:
                nxt_st = cbp_pkg::DMA_IDLE;
        endcase
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            st_ff <= cbp_pkg::DMA_IDLE;                        // [R22]
        else
            st_ff <= nxt_st;
    end

    // Request is held until the bus is freed.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            req_ff <= 1'b0;
        else
            req_ff <= (nxt_st != cbp_pkg::DMA_IDLE);           // [R15]
    end

    // Master strobes: address phase then data read, with wait stretch.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            as_n_ff   <= 1'b1;
            ds_n_ff   <= 1'b1;
            rw_ff     <= 1'b1;
            master_ff <= 1'b0;
        end
        else
        begin
            master_ff <= (nxt_st == cbp_pkg::DMA_ADDR) ||
                         (nxt_st == cbp_pkg::DMA_DATA);        // [R16]
            as_n_ff <= (nxt_st != cbp_pkg::DMA_ADDR);          // [R6]
            ds_n_ff <= (nxt_st != cbp_pkg::DMA_DATA);          // [R9]
            rw_ff   <= 1'b1;                                   // [R14]
        end
    end

    // Master drives the bus only in the address phase, not the data phase.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            ad_oe_ff  <= 1'b0;                                 // [R22]
            dev_ad_ff <= 16'h0000;
            done_ff   <= 1'b0;
            data_ff   <= 16'h0000;
        end
        else
        begin
            done_ff <= 1'b0;
            if (nxt_st == cbp_pkg::DMA_ADDR)
            begin
                ad_oe_ff  <= 1'b1;                             // [R2]
                dev_ad_ff <= dma_addr[15:0];                   // [R1]
            end
            else if (!bus.intack_vec_n && !ds_sync_ff[1] &&
                     st_ff == cbp_pkg::DMA_IDLE)
            begin
                ad_oe_ff  <= 1'b1;
                dev_ad_ff <= {8'h00, int_vector};              // [R4]
            end
            else if (slave_rd_ff && !ds_sync_ff[1])
            begin
                ad_oe_ff  <= 1'b1;                             // [R8]
                dev_ad_ff <= rd_data;
            end
            else
                ad_oe_ff  <= 1'b0;                             // [R24]
            if (st_ff == cbp_pkg::DMA_DATA && nxt_st == cbp_pkg::DMA_DONE)
            begin
                done_ff <= acked;
                data_ff <= bus.ad_in;
            end
        end
    end

    // High address byte would appear on low lanes in a latch cycle.
    logic unused_hi;
    assign unused_hi = ^{dma_addr[23:16], `CBP_LOW_W'(0)};     // [R3]

    ////////////////////////////////////////////////////////////////////
    // Slave side: select and command latched at the address strobe.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            cs_lat_ff   <= 1'b0;
            cd_lat_ff   <= 1'b0;
            hi_phase_ff <= 1'b0;
            slave_rd_ff <= 1'b0;
            wr_stb_ff   <= 1'b0;
            wr_cmd_ff   <= 1'b0;
            wr_data_ff  <= 16'h0000;
            mode2_ff    <= 16'h0000;
        end
        else
        begin
            wr_stb_ff <= 1'b0;
            if (as_sync_ff[1] == 1'b0 && !req_ff)
            begin
                cs_lat_ff <= ~bus.chip_sel_n;                  // [R5]
                cd_lat_ff <= bus.cmd_data;                     // [R23]
            end
            hi_phase_ff <= 1'b0;
            slave_rd_ff <= cs_lat_ff && bus.rd_wr && !req_ff;  // [R13]
            if (ds_fall && cs_lat_ff && !bus.rd_wr && !req_ff)
            begin
                wr_stb_ff  <= 1'b1;                            // [R8]
                wr_cmd_ff  <= cd_lat_ff;                       // [R23]
                wr_data_ff <= bus.ad_in;
                if (!cd_lat_ff)
                    mode2_ff <= bus.ad_in;
            end
            if (ds_rise)
                cs_lat_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    assign bus.dev_ad_out        = dev_ad_ff;
    assign bus.dev_ad_oe         = ad_oe_ff;
    assign bus.addr_strobe_n_dev = as_n_ff;
    assign bus.addr_strobe_oe    = req_ff & acked;             // [R24]
    assign bus.data_strobe_n_dev = ds_n_ff;
    assign bus.rd_wr_dev         = rw_ff;                      // [R12]
    assign bus.bus_req_n_dev     = 1'b0;
    assign bus.bus_req_oe        = req_ff;
    // Pass-through stays combinational so lower requesters see no lag.
    assign bus.bus_ack_out_n     = req_ff | bus.bus_ack_in_n;  // [R17] [R21]
    assign dma_done  = done_ff;
    assign dma_data  = data_ff;
    assign is_master = master_ff;
    assign wr_stb    = wr_stb_ff;
    assign wr_cmd    = wr_cmd_ff;
    assign wr_data   = wr_data_ff;
    assign mode2     = mode2_ff;                               // [R19]
endmodule

// ===== hdl/cbp_host_end.sv
`timescale 1ns/10ps
module cbp_host_end (
    input  wire logic        mclk,      // System clock.
    input  wire logic        rst,       // Async reset, high.
    cbp_bus_if.host          bus,       // Shared bus.
    input  wire logic        go,        // Start slave access pulse.
    input  wire logic        go_rd,     // 1 read, 0 write.
    input  wire logic        go_cmd,    // Command/data select.
    input  wire logic [15:0] go_data,   // Write data.
    input  wire logic        grant,     // Arbiter grants device.
    input  wire logic        mem_wait,  // Memory wants wait.
    input  wire logic [15:0] mem_data,  // Memory word.
    output logic             busy,      // Access in progress.
    output logic [15:0]      rdata      // Read result.
);
    logic [2:0]  ph_ff;
    logic        rd_ff;
    logic        cmd_ff;
    logic [15:0] dat_ff;
    logic [15:0] rdata_ff;
    logic        ack_ff;
    logic        wait_ff;

    // Phases: 1 addr strobe, 2-6 data strobe, 7 release.
    // The data strobe is long because the slave side synchronises it.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            ph_ff    <= 3'h0;
            rd_ff    <= 1'b1;
            cmd_ff   <= 1'b0;
            dat_ff   <= 16'h0000;
            rdata_ff <= 16'h0000;
        end
        else if (ph_ff == 3'h0)
        begin
            if (go && !grant)
            begin
                ph_ff  <= 3'h1;
                rd_ff  <= go_rd;                               // [R13]
                cmd_ff <= go_cmd;
                dat_ff <= go_data;
            end
        end
        else
        begin
            ph_ff <= (ph_ff == 3'h7) ? 3'h0 : ph_ff + 3'h1;
            if (ph_ff == 3'h6)
                rdata_ff <= bus.ad_in;
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            ack_ff  <= 1'b1;
            wait_ff <= 1'b1;
        end
        else
        begin
            ack_ff  <= ~grant;                                 // [R18]
            wait_ff <= ~mem_wait;                              // [R11]
        end
    end

    assign busy                   = ph_ff != 3'h0;
    assign rdata                  = rdata_ff;
    assign bus.chip_sel_n         = ph_ff == 3'h0;             // [R10]
    assign bus.cmd_data           = cmd_ff;
    assign bus.addr_strobe_n_host = ph_ff != 3'h1;             // [R1]
    assign bus.data_strobe_n_host = !(ph_ff >= 3'h2 && ph_ff <= 3'h6);
    assign bus.rd_wr_host         = rd_ff;                     // [R12]
    // Memory answers within the data strobe so the fetch edge sees it.
    assign bus.host_ad_oe         = (bus.addr_strobe_oe &
                                     ~bus.data_strobe_n) |
                                    (busy & (!rd_ff | ph_ff == 3'h1));
    assign bus.host_ad_out        = bus.addr_strobe_oe ? mem_data
                                                       : dat_ff; // [R2]
    assign bus.wait_n             = wait_ff;
    assign bus.bus_ack_in_n       = ack_ff;
    assign bus.intack_vec_n       = 1'b1;
endmodule

// ===== bench/cbp_bus_asserts.sv
`timescale 1ns/10ps
module cbp_bus_asserts (
    input wire logic mclk,              // System clock.
    input wire logic rst,               // Async reset, high.
    input wire logic dev_ad_oe,         // Device drives bus.
    input wire logic addr_strobe_oe,    // Device is master.
    input wire logic addr_strobe_n_dev, // Device address strobe.
    input wire logic data_strobe_n_dev, // Device data strobe.
    input wire logic rd_wr_dev,         // Device direction.
    input wire logic wait_n,            // Wait line.
    input wire logic bus_req_n_dev,     // Request drive value.
    input wire logic bus_req_oe,        // Request enable.
    input wire logic bus_req_n,         // Request wire.
    input wire logic bus_ack_in_n,      // Acknowledge in.
    input wire logic bus_ack_out_n,     // Acknowledge out.
    input wire logic intack_vec_n,      // Vector cycle.
    input wire logic data_strobe_n,     // Resolved data strobe.
    input wire logic rd_wr              // Resolved direction.
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    ////////////////////////////////////////////////////////////////////////
    AST_FLOAT_IDLE: assert property (dev_ad_oe |->
        addr_strobe_oe || !intack_vec_n || rd_wr)
        else $error("device drives bus while not master");
    AST_REQ_HELD: assert property (addr_strobe_oe |->
        bus_req_oe && !bus_req_n_dev)
        else $error("request dropped while master");
    AST_ACK_SYNC: assert property ($rose(addr_strobe_oe) |->
        !$past(bus_ack_in_n) && !$past(bus_ack_in_n, 2))
        else $error("mastership before synchronised acknowledge");
    AST_ACK_THRU: assert property (!bus_req_oe |->
        bus_ack_out_n == bus_ack_in_n)
        else $error("acknowledge not passed through");
    AST_ACK_HIGH: assert property (bus_req_oe && !bus_req_n_dev |->
        bus_ack_out_n)
        else $error("acknowledge out low while requesting");
    AST_REQ_SAMPLE: assert property ($rose(bus_req_oe) |->
        $past(bus_req_n))
        else $error("request driven over a busy request line");
    AST_RW_STABLE: assert property (addr_strobe_oe &&
        $past(addr_strobe_oe) |-> $stable(rd_wr_dev))
        else $error("direction changed within bus cycle");
    AST_RW_READ: assert property (addr_strobe_oe &&
        !addr_strobe_n_dev |-> rd_wr_dev)
        else $error("fetch not marked as read");
    AST_ADDR_DRIVE: assert property (addr_strobe_oe &&
        !addr_strobe_n_dev |-> dev_ad_oe)
        else $error("address strobe without address on bus");
    AST_WAIT_HOLD: assert property (@(negedge mclk)
        addr_strobe_oe && !data_strobe_n_dev && !wait_n |=> !data_strobe_n_dev)
        else $error("data strobe not stretched by wait");
    AST_RELEASE: assert property (bus_ack_in_n [*4] |->
        !addr_strobe_oe)
        else $error("bus kept after acknowledge withdrawn");

    cover property ($rose(addr_strobe_oe));
    cover property (addr_strobe_oe && !data_strobe_n_dev && !wait_n);
    cover property (!addr_strobe_oe && !data_strobe_n);
endmodule

// ===== bench/testbench.sv
`timescale 1ns/10ps
module testbench;
    logic        mclk, rst, dma_go, dma_done, is_master, wr_stb, wr_cmd;
    logic [23:0] dma_addr;
    logic [7:0]  int_vector;
    logic [15:0] rd_data, dma_data, wr_data, mode2, go_data, mem_data, rdata;
    logic        go, go_rd, go_cmd, grant, mem_wait, busy;
    logic        wr_seen, wr_c, done_seen;
    logic [15:0] wr_d, m2;
    int          miscompares, num_checks, seed, cyc, t0, n;
    cbp_bus_if bus ();

    cbp_dev_port #(.SYNC_DEPTH(2)) cbp_dev_port_inst (
        .mclk(mclk), .rst(rst), .bus(bus.dev), .dma_go(dma_go),
        .dma_addr(dma_addr), .int_vector(int_vector), .rd_data(rd_data),
        .dma_done(dma_done), .dma_data(dma_data), .is_master(is_master),
        .wr_stb(wr_stb), .wr_cmd(wr_cmd), .wr_data(wr_data), .mode2(mode2));
    cbp_host_end cbp_host_end_inst (
        .mclk(mclk), .rst(rst), .bus(bus.host), .go(go), .go_rd(go_rd),
        .go_cmd(go_cmd), .go_data(go_data), .grant(grant),
        .mem_wait(mem_wait), .mem_data(mem_data), .busy(busy), .rdata(rdata));
    cbp_bus_asserts cbp_bus_asserts_inst (
        .mclk(mclk), .rst(rst), .dev_ad_oe(bus.dev_ad_oe),
        .addr_strobe_oe(bus.addr_strobe_oe),
        .addr_strobe_n_dev(bus.addr_strobe_n_dev),
        .data_strobe_n_dev(bus.data_strobe_n_dev), .rd_wr_dev(bus.rd_wr_dev),
        .wait_n(bus.wait_n), .bus_req_n_dev(bus.bus_req_n_dev),
        .bus_req_oe(bus.bus_req_oe), .bus_req_n(bus.bus_req_n),
        .bus_ack_in_n(bus.bus_ack_in_n), .bus_ack_out_n(bus.bus_ack_out_n),
        .intack_vec_n(bus.intack_vec_n), .data_strobe_n(bus.data_strobe_n),
        .rd_wr(bus.rd_wr));

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        mclk = 0;
        forever #50 mclk = ~mclk;
    end

    // Pulses are caught here so that a check never races the strobe edge.
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (wr_stb === 1'b1)
        begin
            wr_seen <= 1;
            wr_d <= wr_data;
            wr_c <= wr_cmd;
        end
        if (dma_done === 1'b1)
            done_seen <= 1;
    end

    task automatic tick(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask

    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        num_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: flag %b want %b", $time, got, exp);
        end
    endtask

    function automatic logic [15:0] exp_mode(input logic [15:0] old,
                                             input logic c,
                                             input logic [15:0] d);
        return c ? old : d;
    endfunction

    task automatic close_out;
        if (miscompares == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic host_xfer(input logic r, input logic c,
                             input logic [15:0] d);
        wr_seen = 0;
        go = 1;
        go_rd = r;
        go_cmd = c;
        go_data = d;
        tick(1);
        go = 0;
        n = 0;
        tick(1);
        while (busy !== 1'b0 && n < 50)
        begin
            tick(1);
            n++;
        end
        chk1(n < 50, 1'b1);
        tick(1);
    endtask

    task automatic wait_master(input int lim);
        n = 0;
        while (is_master !== 1'b1 && n < lim)
        begin
            tick(1);
            n++;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        #2000000;
        miscompares++;
        close_out();
    end

    initial
    begin
        seed = 55;
        rst = 1;
        cyc = 0;
        {dma_go, dma_addr, rd_data, go, go_rd, go_cmd, go_data} = '0;
        {grant, mem_wait, mem_data, wr_seen, done_seen} = '0;
        int_vector = 8'h3C;
        tick(2);
        rst = 0;
        chk1(bus.dev_ad_oe, 1'b0);
        chk1(bus.addr_strobe_oe, 1'b0);
        chk16(mode2 & 16'h01FF, 16'h0000);
        for (int i = 0; i < 4; i++)
        begin
            grant = i[0];
            tick(2);
            chk1(bus.bus_ack_out_n, !grant);
        end
        grant = 0;
        tick(2);
        m2 = 16'h0000;
        for (int i = 0; i < 8; i++)
        begin
            go_cmd = (i < 2) ? 1'b0 : 1'($random(seed));
            go_data = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 :
                      16'($random(seed));
            m2 = exp_mode(m2, go_cmd, go_data);
            host_xfer(1'b0, go_cmd, go_data);
            chk1(wr_seen, 1'b1);
            chk16(wr_d, go_data);
            chk1(wr_c, go_cmd);
            chk16(mode2, m2);
            rd_data = 16'($random(seed));
            host_xfer(1'b1, 1'($random(seed)), 16'h0000);
            chk16(rdata, rd_data);
            chk1(wr_seen, 1'b0);
        end
        for (int i = 0; i < 4; i++)
        begin
            mem_data = 16'($random(seed));
            dma_addr = 24'($random(seed));
            mem_wait = i[0];
            done_seen = 0;
            dma_go = 1;
            grant = 1;
            t0 = cyc;
            tick(1);
            dma_go = 0;
            wait_master(50);
            chk1(cyc - t0 >= 3, 1'b1);
            tick(3);
            mem_wait = 0;
            n = 0;
            while (done_seen !== 1'b1 && n < 100)
            begin
                tick(1);
                n++;
            end
            chk1(done_seen, 1'b1);
            chk16(dma_data, mem_data);
            grant = 0;
            tick(6);
            chk1(bus.dev_ad_oe, 1'b0);
        end
        // Withdrawing the grant mid-stretch leaves the fetch unfinished.
        mem_wait = 1;
        dma_go = 1;
        grant = 1;
        tick(1);
        dma_go = 0;
        wait_master(50);
        tick(2);
        grant = 0;
        tick(6);
        chk1(is_master, 1'b0);
        chk1(bus.addr_strobe_oe, 1'b0);
        mem_wait = 0;
        tick(10);
        close_out();
    end
endmodule
